// *** inc/ssr_pkg.sv ***
// Purpose: shared constants and types of the status reporting block
// Assumes: 16-bit status parts, 8-bit register byte address space
// Notes:   group registers sit at group index * 32 plus field offset
package ssr_pkg;
	localparam int          REG_W        = 16;
	localparam int          NGRP         = 5;
	localparam logic [2:0]  GRP_OPER     = 3'h0;
	localparam logic [2:0]  GRP_QUES     = 3'h1;
	localparam logic [2:0]  GRP_FREQ     = 3'h2;
	localparam logic [2:0]  GRP_LIM      = 3'h3;
	localparam logic [2:0]  GRP_POW      = 3'h4;
	// -----------------------------------------------------------------
	// reset and preset values
	// -----------------------------------------------------------------
	localparam logic [15:0] EN_CLEAR     = 16'h0000;
	localparam logic [15:0] EN_FILL      = 16'hFFFF;
	localparam logic [15:0] PTR_PRESET   = 16'hFFFF;
	localparam logic [15:0] NTR_PRESET   = 16'h0000;
	localparam logic [15:0] PTR_RESET    = 16'hFFFF;
	localparam logic [15:0] NTR_RESET    = 16'h0000;
	localparam logic [15:0] EN_RESET     = 16'h0000;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [4:0]  OFS_COND     = 5'h00;
	localparam logic [4:0]  OFS_EVENT    = 5'h04;
	localparam logic [4:0]  OFS_ENABLE   = 5'h08;
	localparam logic [4:0]  OFS_PTR      = 5'h0C;
	localparam logic [4:0]  OFS_NTR      = 5'h10;
	localparam logic [7:0]  ADDR_CTRL    = 8'hA0;
	localparam logic [7:0]  ADDR_QUEUE   = 8'hA4;
	localparam logic [7:0]  ADDR_IRQ_ST  = 8'hA8;
	localparam logic [7:0]  ADDR_IRQ_MSK = 8'hAC;
	localparam logic [7:0]  ADDR_SRE     = 8'hB0;
	localparam logic [7:0]  ADDR_STB     = 8'hB4;
	localparam int          CTRL_PRESET  = 0;
	localparam int          CTRL_GENRST  = 1;
	localparam int          Q_NOERR_BIT  = 16;
	// -----------------------------------------------------------------
	// summary bit positions
	// -----------------------------------------------------------------
	localparam int          QUES_FREQ_BIT = 5;
	localparam int          QUES_LIM_BIT  = 9;
	localparam int          QUES_POW_BIT  = 3;
	localparam int          STB_ERR_BIT  = 2;
	localparam int          STB_QUES_BIT = 3;
	localparam int          STB_MAV_BIT  = 4;
	localparam int          STB_ESB_BIT  = 5;
	localparam int          STB_RQS_BIT  = 6;
	localparam int          STB_OPER_BIT = 7;
	localparam logic [7:0]  STB_SRQ_MASK = 8'hBC;
	localparam int          IRQ_W        = 4;
	localparam int          IRQ_OPER     = 0;
	localparam int          IRQ_QUES     = 1;
	localparam int          IRQ_ERR      = 2;
	localparam int          IRQ_OVF      = 3;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic [15:0] en;
		logic [15:0] ptr;
		logic [15:0] ntr;
	} ssr_cfg_s;

	typedef logic signed [15:0] ssr_err_t;
endpackage

// *** sim/ssr_host.sv ***
// Purpose: controller side model, AXI4-Lite master issuing status commands
// Assumes: slave answers in its own time, one write and one read at a time
// Notes:   signals change by non-blocking assignment just after aclk rises
`timescale 1ns/1ps
module ssr_host (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic [2:0]       awprot,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic [2:0]       arprot,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial begin
		{awaddr, araddr, awprot, arprot} = 22'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
	end

	// full 32-bit words only: every mask and filter value fits 0..65535
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			r = bresp;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			d = rdata;
			r = rresp;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask
endmodule

// *** sim/tb_ssr_top.sv ***
// Purpose: self-checking bench of the status reporting block
// Assumes: 40 MHz aclk, reset low for 5 cycles
// Notes:   expected values follow from the status rules and package constants
`timescale 1ns/1ps
module tb_ssr_top;
	import ssr_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, err_push, mav, esb, srq, irq, gen_rst;
	logic [7:0]  awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] oper_c, ques_c, freq_c, lim_c, pow_c;
	ssr_err_t    err_code;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          n_gen = 0;

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	ssr_top u_ssr_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.oper_cond_i(oper_c), .ques_cond_i(ques_c), .freq_cond_i(freq_c),
		.lim_cond_i(lim_c), .pow_cond_i(pow_c), .err_push_i(err_push),
		.err_code_i(err_code), .mav_i(mav), .esb_i(esb), .srq_o(srq), .irq_o(irq),
		.gen_reset_o(gen_rst));

	ssr_host u_ssr_host (.aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	always @(posedge aclk)
		if (gen_rst === 1'b1)
			n_gen <= n_gen + 1;

	task automatic stop_test;
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		u_ssr_host.axi_wr(a, v, r);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		u_ssr_host.axi_rd(a, d, r);
		chk(d, exp);
	endtask

	task automatic settle;
		repeat (4) @(posedge aclk);
	endtask

	// whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		stop_test;
	end

	initial begin
		aresetn = 1'b0;
		{oper_c, ques_c, freq_c, lim_c, pow_c} = 80'h0;
		{err_push, mav, esb} = 3'h0;
		err_code = 16'h0000;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int g = 0; g < NGRP; g++) begin
			rchk({g[2:0], OFS_ENABLE}, 32'h0);
			rchk({g[2:0], OFS_PTR}, 32'h0000_FFFF);
			rchk({g[2:0], OFS_NTR}, 32'h0);
			rchk({g[2:0], OFS_EVENT}, 32'h0);
		end
		rchk(ADDR_QUEUE, 32'h0001_0000);
		rchk(ADDR_QUEUE, 32'h0001_0000);
		// rise detection, clear on read, live condition
		oper_c <= 16'h8001;
		settle;
		rchk({GRP_OPER, OFS_COND}, 32'h0000_8001);
		rchk({GRP_OPER, OFS_EVENT}, 32'h0000_8001);
		rchk({GRP_OPER, OFS_EVENT}, 32'h0);
		// falling edges only on the questionable group
		wr({GRP_QUES, OFS_NTR}, 32'h0000_FFFF);
		wr({GRP_QUES, OFS_PTR}, 32'h0);
		rchk({GRP_QUES, OFS_NTR}, 32'h0000_FFFF);
		ques_c <= 16'h0001;
		settle;
		rchk({GRP_QUES, OFS_EVENT}, 32'h0);
		ques_c <= 16'h0000;
		settle;
		rchk({GRP_QUES, OFS_EVENT}, 32'h0000_0001);
		// summary rise drives interrupt and service request
		wr(ADDR_IRQ_MSK, 32'h1);
		wr(ADDR_SRE, 32'h80);
		wr({GRP_OPER, OFS_ENABLE}, 32'h2);
		oper_c <= 16'h8003;
		settle;
		chk(irq, 1'b1);
		chk(srq, 1'b1);
		rchk(ADDR_STB, 32'h0000_00C0);
		rchk({GRP_OPER, OFS_EVENT}, 32'h0000_0002);
		wr(ADDR_IRQ_ST, 32'h1);
		settle;
		chk({irq, srq}, 2'h0);
		// masked interrupt still latches status; mav reaches srq
		wr(ADDR_IRQ_MSK, 32'h0);
		wr(ADDR_SRE, 32'h10);
		oper_c <= 16'h8001;
		mav <= 1'b1;
		settle;
		oper_c <= 16'h8003;
		settle;
		chk({irq, srq}, 2'h1);
		rchk(ADDR_IRQ_ST, 32'h1);
		// general reset leaves status untouched, preset restores defaults
		wr({GRP_FREQ, OFS_PTR}, 32'h0);
		wr({GRP_FREQ, OFS_NTR}, 32'h0000_FFFF);
		wr({GRP_QUES, OFS_ENABLE}, 32'h0000_1234);
		wr(ADDR_CTRL, 32'h2);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		chk(n_gen, 1);
		rchk({GRP_FREQ, OFS_PTR}, 32'h0);
		rchk({GRP_QUES, OFS_ENABLE}, 32'h0000_1234);
		rchk({GRP_OPER, OFS_EVENT}, 32'h0000_0002);
		wr(ADDR_CTRL, 32'h1);
		rchk({GRP_FREQ, OFS_PTR}, 32'h0000_FFFF);
		rchk({GRP_QUES, OFS_PTR}, 32'h0000_FFFF);
		rchk({GRP_FREQ, OFS_NTR}, 32'h0);
		rchk({GRP_QUES, OFS_NTR}, 32'h0);
		rchk({GRP_QUES, OFS_ENABLE}, 32'h0);
		rchk({GRP_OPER, OFS_ENABLE}, 32'h0);
		rchk({GRP_FREQ, OFS_ENABLE}, 32'h0000_FFFF);
		// sub-register summaries in questionable condition
		{freq_c, lim_c, pow_c} <= {16'h0001, 16'h0001, 16'h0001};
		settle;
		rchk({GRP_QUES, OFS_COND}, 32'h0000_0228);
		rchk({GRP_FREQ, OFS_EVENT}, 32'h0000_0001);
		settle;
		rchk({GRP_QUES, OFS_COND}, 32'h0000_0208);
		// questionable summary alone reaches srq once enabled
		wr(ADDR_SRE, 32'h08);
		chk(srq, 1'b0);
		wr({GRP_QUES, OFS_ENABLE}, 32'h0000_0200);
		chk(srq, 1'b1);
		rchk({GRP_QUES, OFS_EVENT}, 32'h0000_0228);
		wr({GRP_LIM, OFS_ENABLE}, 32'h0000_FFFF);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		rchk({GRP_LIM, OFS_ENABLE}, 32'h0000_FFFF);
		// queue order and code signs
		err_push <= 1'b1;
		err_code <= 16'hFFFB;
		@(posedge aclk);
		err_code <= 16'h0007;
		@(posedge aclk);
		err_push <= 1'b0;
		@(posedge aclk);
		rchk(ADDR_STB, 32'h0000_0014);
		rchk(ADDR_QUEUE, 32'h0000_FFFB);
		rchk(ADDR_QUEUE, 32'h0000_0007);
		rchk(ADDR_QUEUE, 32'h0001_0000);
		// unmapped address answers with an error response
		u_ssr_host.axi_rd(8'hFC, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'hFC, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		stop_test;
	end
endmodule

// *** src/ssr_top.sv ***
// Purpose: status condition/transition/event/enable groups, error queue, AXI4-Lite
// Assumes: condition inputs and error pushes come from logic on aclk
// Notes:   one group module instantiated per status register
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

module ssr_group #(
	parameter logic [15:0] PRESET_EN = 16'h0000
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [15:0]      cond_i,
	input  wire logic             en_we,
	input  wire logic             ptr_we,
	input  wire logic             ntr_we,
	input  wire logic [15:0]      wdata,
	input  wire logic [1:0]       wstrb,
	input  wire logic             preset,
	input  wire logic             ev_clr,
	output ssr_pkg::ssr_cfg_s     cfg_q,
	output logic [15:0]           ev_q,
	output logic                  summary_o
);
	import ssr_pkg::*;

	logic [15:0] cond_prev_q;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [15:0] ev_set;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] st);
		merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_prev_q <= 16'h0000;
		end else begin
			cond_prev_q <= cond_i;
		end
	end

	assign rise   = cond_i & ~cond_prev_q & cfg_q.ptr;
	assign fall   = ~cond_i & cond_prev_q & cfg_q.ntr;
	assign ev_set = rise | fall;

	// a new edge in the clearing read cycle survives the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_q <= 16'h0000;
		end else begin
			ev_q <= (ev_clr ? 16'h0000 : ev_q) | ev_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q.en  <= EN_RESET;
			cfg_q.ptr <= PTR_RESET;
			cfg_q.ntr <= NTR_RESET;
		end else if (preset) begin
			cfg_q.ptr <= PTR_PRESET;
			cfg_q.ntr <= NTR_PRESET;
			cfg_q.en  <= PRESET_EN;
		end else begin
			if (en_we) begin
				cfg_q.en <= merge(cfg_q.en, wdata, wstrb);
			end
			if (ptr_we) begin
				cfg_q.ptr <= merge(cfg_q.ptr, wdata, wstrb);
			end
			if (ntr_we) begin
				cfg_q.ntr <= merge(cfg_q.ntr, wdata, wstrb);
			end
		end
	end

	assign summary_o = |(ev_q & cfg_q.en);

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_arm;
		!summary_o && !preset && !en_we && |(ev_set & cfg_q.en);
	endsequence
	sequence s_fire;
		summary_o;
	endsequence

	AST_PRESET_PTR: assert property (preset |=> cfg_q.ptr == PTR_PRESET)
		else $error("ptr not all ones after preset");
	AST_PRESET_NTR: assert property (preset |=> cfg_q.ntr == NTR_PRESET)
		else $error("ntr not zero after preset");
	AST_PRESET_EN: assert property (preset |=> cfg_q.en == PRESET_EN)
		else $error("enable wrong after preset");
	AST_RISE_EV: assert property ((|rise) |=> (ev_q & $past(rise)) == $past(rise))
		else $error("rising edge did not set event");
	AST_FALL_EV: assert property ((|fall) |=> (ev_q & $past(fall)) == $past(fall))
		else $error("falling edge did not set event");
	AST_EV_HOLD: assert property (!ev_clr |=> ($past(ev_q) & ~ev_q) == 16'h0000)
		else $error("event bit lost without clearing read");
	AST_EV_CLR: assert property (ev_clr |=> ev_q == $past(ev_set))
		else $error("event not cleared by read");
	AST_SUMMARY: assert property (s_arm |=> s_fire)
		else $error("summary did not rise on enabled event");
endmodule

// Operation
// - status preset loads every positive transition filter with all ones.
// - status preset clears every negative transition filter.
// - status preset clears operation and questionable enable masks.
// - general instrument reset leaves all status registers untouched.
// - queue read returns oldest entry and removes it.
// - empty queue read returns code zero with no-error flag, stays empty.
// - positive codes are instrument errors, negative ones language-standard errors.
// - reading an event part returns it and clears it.
// - reading a condition part returns live bits, event unchanged.
// - enabled event becoming true raises the summary bit.
// - set positive filter bit makes a 0-to-1 condition change set event.
// - set negative filter bit makes a 1-to-0 condition change set event.
// - masks and filters are 16 bits, any value accepted.
// - operation condition bits show calibration state.
// - questionable conditions show oscillators, overload, limit checks and margins.
// - status behaviour is the same in every operating mode.
// - service request when status byte bits 2,3,4,5,7 set and enabled.
module ssr_top #(
	parameter int ADDR_W = 8,
	parameter int QDEPTH = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [15:0]       oper_cond_i,
	input  wire logic [15:0]       ques_cond_i,
	input  wire logic [15:0]       freq_cond_i,
	input  wire logic [15:0]       lim_cond_i,
	input  wire logic [15:0]       pow_cond_i,
	input  wire logic              err_push_i,
	input  ssr_pkg::ssr_err_t      err_code_i,
	input  wire logic              mav_i,
	input  wire logic              esb_i,
	output logic                   srq_o,
	output logic                   irq_o,
	output logic                   gen_reset_o
);
	import ssr_pkg::*;

	localparam int PW = $clog2(QDEPTH);

	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic              wr_go;
	logic              wr_map;
	logic [7:0]        wa;
	logic              w_ingrp;
	logic              rd_go;
	logic [7:0]        ra;
	logic              r_ingrp;
	logic [31:0]       rd_data;
	logic              rd_map;
	logic              preset;
	ssr_cfg_s          cfg_a [NGRP];
	logic [15:0]       ev_a [NGRP];
	logic [15:0]       cond_a [NGRP];
	logic [NGRP-1:0]   sum_v;
	logic [NGRP-1:0]   en_we;
	logic [NGRP-1:0]   ptr_we;
	logic [NGRP-1:0]   ntr_we;
	logic [NGRP-1:0]   ev_clr;
	ssr_err_t          qmem [QDEPTH];
	logic [PW-1:0]     wptr_q;
	logic [PW-1:0]     rptr_q;
	logic [PW:0]       cnt_q;
	logic              q_empty;
	logic              q_full;
	logic              q_pop;
	logic              q_push;
	logic              q_ovf;
	logic [7:0]        sre_q;
	logic [7:0]        stb;
	logic [1:0]        sum_prev_q;
	logic [IRQ_W-1:0]  irq_st_q;
	logic [IRQ_W-1:0]  irq_msk_q;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clr;

	// -----------------------------------------------------------------
	// write channel: address and data taken in either order
	// -----------------------------------------------------------------
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wa            = 8'(awaddr_q);
	assign w_ingrp       = (wa[7:5] < 3'(NGRP)) && (wa[4:0] >= OFS_ENABLE)
		&& (wa[4:0] <= OFS_NTR) && (wa[1:0] == 2'h0);
	assign wr_map        = w_ingrp || (wa == ADDR_CTRL) || (wa == ADDR_IRQ_ST)
		|| (wa == ADDR_IRQ_MSK) || (wa == ADDR_SRE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// general reset only leaves the block as a pulse; status is not touched
	assign preset = wr_go && (wa == ADDR_CTRL) && wstrb_q[0] && wdata_q[CTRL_PRESET];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gen_reset_o <= 1'b0;
		end else begin
			gen_reset_o <= wr_go && (wa == ADDR_CTRL) && wstrb_q[0]
				&& wdata_q[CTRL_GENRST];
		end
	end

	// -----------------------------------------------------------------
	// status groups
	// -----------------------------------------------------------------
	// no operating mode input exists, so behaviour cannot depend on one
	always_comb begin
		cond_a[GRP_OPER] = oper_cond_i;
		cond_a[GRP_QUES] = ques_cond_i;
		cond_a[GRP_QUES][QUES_FREQ_BIT] = sum_v[GRP_FREQ];
		cond_a[GRP_QUES][QUES_LIM_BIT]  = sum_v[GRP_LIM];
		cond_a[GRP_QUES][QUES_POW_BIT]  = sum_v[GRP_POW];
		cond_a[GRP_FREQ] = freq_cond_i;
		cond_a[GRP_LIM]  = lim_cond_i;
		cond_a[GRP_POW]  = pow_cond_i;
	end

	for (genvar g = 0; g < NGRP; g++) begin : g_grp
		assign en_we[g]  = wr_go && w_ingrp && (wa[7:5] == 3'(g)) && (wa[4:0] == OFS_ENABLE);
		assign ptr_we[g] = wr_go && w_ingrp && (wa[7:5] == 3'(g)) && (wa[4:0] == OFS_PTR);
		assign ntr_we[g] = wr_go && w_ingrp && (wa[7:5] == 3'(g)) && (wa[4:0] == OFS_NTR);
		assign ev_clr[g] = rd_go && r_ingrp && (ra[7:5] == 3'(g)) && (ra[4:0] == OFS_EVENT);
		ssr_group #(
			.PRESET_EN ((g == GRP_OPER || g == GRP_QUES) ? EN_CLEAR : EN_FILL)
		) u_grp (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.cond_i    (cond_a[g]),
			.en_we     (en_we[g]),
			.ptr_we    (ptr_we[g]),
			.ntr_we    (ntr_we[g]),
			.wdata     (wdata_q[15:0]),
			.wstrb     (wstrb_q[1:0]),
			.preset    (preset),
			.ev_clr    (ev_clr[g]),
			.cfg_q     (cfg_a[g]),
			.ev_q      (ev_a[g]),
			.summary_o (sum_v[g])
		);
	end

	// -----------------------------------------------------------------
	// error queue
	// -----------------------------------------------------------------
	// a push into a full queue is dropped unless a queue read pops in the same cycle; the overflow flag reports it
	assign q_empty = (cnt_q == '0);
	assign q_full  = (cnt_q == (PW+1)'(QDEPTH));
	assign q_pop   = rd_go && (ra == ADDR_QUEUE) && !q_empty;
	assign q_push  = err_push_i && (!q_full || q_pop);
	assign q_ovf   = err_push_i && q_full && !q_pop;

	always_ff @(posedge aclk) begin
		if (q_push) begin
			qmem[wptr_q] <= err_code_i;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end else begin
			if (q_push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (q_pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
			if (q_push && !q_pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (q_pop && !q_push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// read channel
	// -----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go         = s_axi_arvalid && s_axi_arready;
	assign ra            = 8'(s_axi_araddr);
	assign r_ingrp       = (ra[7:5] < 3'(NGRP)) && (ra[4:0] <= OFS_NTR) && (ra[1:0] == 2'h0);

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_map  = 1'b1;
		if (r_ingrp) begin
			case (ra[4:0])
				OFS_COND:   rd_data[15:0] = cond_a[ra[7:5]];
				OFS_EVENT:  rd_data[15:0] = ev_a[ra[7:5]];
				OFS_ENABLE: rd_data[15:0] = cfg_a[ra[7:5]].en;
				OFS_PTR:    rd_data[15:0] = cfg_a[ra[7:5]].ptr;
				OFS_NTR:    rd_data[15:0] = cfg_a[ra[7:5]].ntr;
				default:    rd_map = 1'b0;
			endcase
		end else begin
			case (ra)
				ADDR_CTRL:    rd_data = 32'h0000_0000;
				ADDR_QUEUE: begin
					if (q_empty) begin
						rd_data[Q_NOERR_BIT] = 1'b1;
					end else begin
						rd_data[15:0] = qmem[rptr_q];
					end
				end
				ADDR_IRQ_ST:  rd_data[IRQ_W-1:0] = irq_st_q;
				ADDR_IRQ_MSK: rd_data[IRQ_W-1:0] = irq_msk_q;
				ADDR_SRE:     rd_data[7:0] = sre_q;
				ADDR_STB:     rd_data[7:0] = stb;
				default:      rd_map = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_data;
			s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// status byte, service request, interrupt
	// -----------------------------------------------------------------
	always_comb begin
		stb               = 8'h00;
		stb[STB_ERR_BIT]  = !q_empty;
		stb[STB_QUES_BIT] = sum_v[GRP_QUES];
		stb[STB_MAV_BIT]  = mav_i;
		stb[STB_ESB_BIT]  = esb_i;
		stb[STB_RQS_BIT]  = srq_o;
		stb[STB_OPER_BIT] = sum_v[GRP_OPER];
	end

	assign irq_set[IRQ_OPER] = sum_v[GRP_OPER] && !sum_prev_q[0];
	assign irq_set[IRQ_QUES] = sum_v[GRP_QUES] && !sum_prev_q[1];
	assign irq_set[IRQ_ERR]  = q_push;
	assign irq_set[IRQ_OVF]  = q_ovf;
	assign irq_clr = (wr_go && (wa == ADDR_IRQ_ST) && wstrb_q[0]) ?
		wdata_q[IRQ_W-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sre_q      <= 8'h00;
			irq_msk_q  <= '0;
			irq_st_q   <= '0;
			sum_prev_q <= 2'h0;
			srq_o      <= 1'b0;
			irq_o      <= 1'b0;
		end else begin
			if (wr_go && (wa == ADDR_SRE) && wstrb_q[0]) begin
				sre_q <= wdata_q[7:0];
			end
			if (wr_go && (wa == ADDR_IRQ_MSK) && wstrb_q[0]) begin
				irq_msk_q <= wdata_q[IRQ_W-1:0];
			end
			irq_st_q   <= (irq_st_q & ~irq_clr) | irq_set;
			sum_prev_q <= {sum_v[GRP_QUES], sum_v[GRP_OPER]};
			srq_o      <= |(stb & sre_q & STB_SRQ_MASK);
			irq_o      <= |(irq_st_q & irq_msk_q);
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [NGRP*48-1:0] cfg_all;
	always_comb begin
		cfg_all = '0;
		for (int i = 0; i < NGRP; i++) begin
			cfg_all[i*48 +: 48] = cfg_a[i];
		end
	end

	AST_GENRST: assert property (gen_reset_o && !$past(preset) |-> $stable(cfg_all))
		else $error("general reset altered status setup");
	AST_Q_POP: assert property (q_pop && !q_push |=> cnt_q == $past(cnt_q) - 1'b1)
		else $error("queue read did not remove entry");
	AST_Q_EMPTY: assert property (rd_go && ra == ADDR_QUEUE && q_empty |=>
		s_axi_rdata == 32'h0001_0000 && s_axi_rvalid)
		else $error("empty queue read wrong");
	AST_COND_RD: assert property (rd_go && ra == {GRP_OPER, OFS_COND} |=>
		($past(ev_a[GRP_OPER]) & ~ev_a[GRP_OPER]) == 16'h0000)
		else $error("condition read cleared an event");
	AST_SRQ: assert property ($rose(sum_v[GRP_QUES]) && sre_q[STB_QUES_BIT] |=> srq_o)
		else $error("service request missing");
	AST_SUB_SUM: assert property (cond_a[GRP_QUES][QUES_LIM_BIT] == sum_v[GRP_LIM])
		else $error("limit summary not in questionable condition");
endmodule
